// ### hdl/ddc_decimator.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ddc_decimator (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  // Register port
  input  wire logic [ddc_pkg::REG_AW-1:0]      reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [31:0]                     reg_rdata,
  // Converter samples
  input  wire logic signed [ddc_pkg::IN_W-1:0] samp_a,
  input  wire logic signed [ddc_pkg::IN_W-1:0] samp_b,
  input  wire logic                            samp_valid,
  output logic                                 samp_ready,
  // Power-down or sync pin
  input  wire logic                            powerdown_or_align_pin,
  output logic                                 powered_down,
  // Decimated output, one lane per channel
  output ddc_pkg::out_word_s [1:0]             out_word,
  output logic [1:0]                           out_valid,
  input  wire logic [1:0]                      out_ready
);
  import ddc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sixteen-step cosine from quarter-wave table
  function automatic logic signed [15:0] cos16(input logic [3:0] k);
    logic signed [15:0] v;
    v = 16'sh0000;
    if (k <= 4'h4) v = COS_TAB[3'(k)];
    else if (k <= 4'h8) v = -COS_TAB[3'(4'h8 - k)];
    else if (k <= 4'hC) v = -COS_TAB[3'(k - 4'h8)];
    else v = COS_TAB[3'(5'h10 - {1'b0, k})];
    return v;
  endfunction

  // Gain stages with saturation; 3 dB is a shift-add near 1.406
  function automatic logic signed [CALC_W-1:0] gain_fn(
    input logic signed [CALC_W-1:0] v,
    input logic                     g6,
    input logic                     g3);
    logic signed [21:0] w;
    w = 22'(v);
    if (g6) w = w <<< 1;
    if (g3) w = w + (w >>> 2) + (w >>> 3) + (w >>> 5);
    if (w > SAT_HI) return SAT_HI[CALC_W-1:0];
    if (w < SAT_LO) return SAT_LO[CALC_W-1:0];
    return w[CALC_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Register file and sync
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [NCO_W-1:0]  freq_q [2];
  logic [NCO_W-1:0]  freq_d [2];
  logic [31:0]       rdata_q, rdata_d;
  logic              pin_prev_q, pin_prev_d;
  logic              restart_prev_q, restart_prev_d;
  logic              rdy_q, rdy_d;
  logic              pd_q, pd_d;
  logic              align_ev;
  logic [2:0]        dec_code;
  logic [1:0]        ch_ok;
  logic [4:0]        cnt_view [2];
  logic [NCO_W-1:0]  live_view [2];
  logic signed [IN_W-1:0] samp [2];
  logic              accept;

  assign samp[0] = samp_a;
  assign samp[1] = samp_b;
  assign accept  = samp_valid & rdy_q;
  // Codes above 4 clamp to the deepest factor
  assign dec_code = (ctrl_q[B_DEC_LO +: 3] > DEC_CODE_MAX) ?
                    DEC_CODE_MAX : ctrl_q[B_DEC_LO +: 3];
  // Restart bit rising, or pin rising when it serves as sync
  assign align_ev = (ctrl_q[B_RESTART] & ~restart_prev_q) |
                    (ctrl_q[B_SYNC_EN] & powerdown_or_align_pin &
                     ~pin_prev_q);

  // Register decode, read data, ready and power-down
  always_comb begin
    ctrl_d         = ctrl_q;
    freq_d         = freq_q;
    rdata_d        = 32'h00000000;
    pin_prev_d     = powerdown_or_align_pin;
    restart_prev_d = ctrl_q[B_RESTART];
    // Pin acts as power-down unless sync is enabled
    pd_d           = ~ctrl_q[B_SYNC_EN] & powerdown_or_align_pin;
    rdy_d          = ~pd_d & (&ch_ok);
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL:   ctrl_d    = reg_wdata[CTRL_W-1:0];
        OFS_FREQ_A: freq_d[0] = reg_wdata;
        OFS_FREQ_B: freq_d[1] = reg_wdata;
        default:    ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:   rdata_d = {20'h00000, ctrl_q};
        OFS_FREQ_A: rdata_d = freq_q[0];
        OFS_FREQ_B: rdata_d = freq_q[1];
        OFS_STAT:   rdata_d = {25'h0000000, cnt_view[0], rdy_q, pd_q};
        OFS_LIVE_A: rdata_d = live_view[0];
        OFS_LIVE_B: rdata_d = live_view[1];
        default:    rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q         <= CTRL_RST;
      freq_q[0]      <= FREQ_RST;
      freq_q[1]      <= FREQ_RST;
      rdata_q        <= 32'h00000000;
      pin_prev_q     <= 1'b0;
      restart_prev_q <= 1'b0;
      rdy_q          <= 1'b0;
      pd_q           <= 1'b0;
    end else begin
      ctrl_q         <= ctrl_d;
      freq_q         <= freq_d;
      rdata_q        <= rdata_d;
      pin_prev_q     <= pin_prev_d;
      restart_prev_q <= restart_prev_d;
      rdy_q          <= rdy_d;
      pd_q           <= pd_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign samp_ready   = rdy_q;
  assign powered_down = pd_q;

  // ----------------------------------------------------------------
  // Per-channel path: crossbar, mixer, decimator, two-entry buffer
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic signed [ACC_W-1:0]  acc_i_q, acc_i_d, acc_q_q, acc_q_d;
    logic [4:0]               cnt_q, cnt_d;
    logic [NCO_W-1:0]         phase_q, phase_d, live_q, live_d;
    logic [1:0]               rot_q, rot_d;
    emit_e                    emit_q, emit_d;
    logic signed [OUT_W-1:0]  held_q, held_d;
    out_word_s                main_q, main_d, skid_q, skid_d;
    logic                     mv_q, mv_d, sv_q, sv_d;

    logic signed [IN_W-1:0]   x;
    logic signed [15:0]       cv, sv;
    logic signed [29:0]       prod_i, prod_q;
    logic signed [CALC_W-1:0] mi, mq, ri, rq;
    logic signed [ACC_W-1:0]  sum_i, sum_q;
    logic signed [OUT_W-1:0]  ti, tq;
    logic [4:0]               last_cnt;
    logic                     push;
    out_word_s                push_w;

    // Crossbar ahead of the filter
    assign x = ctrl_q[B_CROSS] ? samp[1-ch] : samp[ch];
    assign last_cnt = CNT_FULL >> (3'h4 - dec_code);
    assign ch_ok[ch] = (emit_d == EMIT_MAIN) & ~sv_d;
    assign cnt_view[ch] = cnt_q;
    assign live_view[ch] = live_q;

    // Oscillator lookup; top phase bits pick the step
    always_comb begin
      cv = cos16(phase_q[NCO_W-1 -: 4]);
      sv = cos16(phase_q[NCO_W-1 -: 4] - 4'h4);
      prod_i = x * cv;
      prod_q = x * sv;
      if (ctrl_q[B_REAL]) begin
        mi = {x[IN_W-1], x, 5'h00};
        mq = 20'sh00000;
      end else begin
        mi = prod_i[29 -: CALC_W];
        // Inverted phase gives the negative rotation
        mq = ctrl_q[B_INV] ? -prod_q[29 -: CALC_W] : prod_q[29 -: CALC_W];
      end
      sum_i = acc_i_q + ACC_W'(mi);
      sum_q = acc_q_q + ACC_W'(mq);
      // Integrate-and-dump; normalising shift keeps unity DC gain
      ri = gain_fn(CALC_W'(sum_i >>> (dec_code + 3'h1)),
                   ctrl_q[B_G6] & ~ctrl_q[B_REAL],
                   ctrl_q[B_G3] & ctrl_q[B_REAL]);
      rq = gain_fn(CALC_W'(sum_q >>> (dec_code + 3'h1)),
                   ctrl_q[B_G6] & ~ctrl_q[B_REAL], 1'b0);
      ti = ri[CALC_W-1 -: OUT_W];
      tq = rq[CALC_W-1 -: OUT_W];
    end

    // Sequencing, quarter-rate mix and buffer next state
    always_comb begin
      acc_i_d = acc_i_q;
      acc_q_d = acc_q_q;
      cnt_d   = cnt_q;
      phase_d = phase_q;
      live_d  = live_q;
      rot_d   = rot_q;
      emit_d  = emit_q;
      held_d  = held_q;
      main_d  = main_q;
      skid_d  = skid_q;
      mv_d    = mv_q;
      sv_d    = sv_q;
      push    = 1'b0;
      push_w  = '0;
      // Drain side first frees a slot this cycle
      if (mv_q && out_ready[ch]) begin
        main_d = skid_q;
        mv_d   = sv_q;
        sv_d   = 1'b0;
      end
      if (align_ev) begin
        cnt_d   = 5'h00;
        acc_i_d = '0;
        acc_q_d = '0;
        phase_d = '0;
        live_d  = freq_q[ch];
        rot_d   = 2'h0;
      end else if (accept && !ctrl_q[B_EN]) begin
        push   = 1'b1;
        push_w = '{real_fmt: 1'b1, i: {x, 2'h0}, q: 16'sh0000};
      end else if (accept) begin
        phase_d = phase_q + live_q;
        if (cnt_q == last_cnt) begin
          // One complex result per N inputs, I and Q together
          cnt_d   = 5'h00;
          acc_i_d = '0;
          acc_q_d = '0;
          push    = 1'b1;
          if (ctrl_q[B_FS4] && !ctrl_q[B_REAL]) begin
            // Re((I+jQ)*j^k): I, -Q, -I, Q as two real words
            push_w = '{real_fmt: 1'b1, i: rot_q[1] ? -ti : ti, q: 16'sh0000};
            held_d = rot_q[1] ? tq : -tq;
            rot_d  = rot_q + 2'h2;
            emit_d = EMIT_SECOND;
          end else begin
            push_w = '{real_fmt: ctrl_q[B_REAL], i: ti, q: tq};
          end
        end else begin
          cnt_d   = cnt_q + 5'h01;
          acc_i_d = sum_i;
          acc_q_d = sum_q;
        end
      end
      // Second real word waits for a free slot
      if (emit_q == EMIT_SECOND && !sv_q) begin
        push   = 1'b1;
        push_w = '{real_fmt: 1'b1, i: held_q, q: 16'sh0000};
        emit_d = EMIT_MAIN;
      end
      if (push) begin
        if (!mv_d) begin
          main_d = push_w;
          mv_d   = 1'b1;
        end else begin
          skid_d = push_w;
          sv_d   = 1'b1;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        acc_i_q <= '0;
        acc_q_q <= '0;
        cnt_q   <= 5'h00;
        phase_q <= '0;
        live_q  <= FREQ_RST;
        rot_q   <= 2'h0;
        emit_q  <= EMIT_MAIN;
        held_q  <= 16'sh0000;
        main_q  <= '0;
        skid_q  <= '0;
        mv_q    <= 1'b0;
        sv_q    <= 1'b0;
      end else begin
        acc_i_q <= acc_i_d;
        acc_q_q <= acc_q_d;
        cnt_q   <= cnt_d;
        phase_q <= phase_d;
        live_q  <= live_d;
        rot_q   <= rot_d;
        emit_q  <= emit_d;
        held_q  <= held_d;
        main_q  <= main_d;
        skid_q  <= skid_d;
        mv_q    <= mv_d;
        sv_q    <= sv_d;
      end
    end

    assign out_word[ch]  = main_q;
    assign out_valid[ch] = mv_q;
  end
endmodule
`default_nettype wire

// ### hdl/ddc_pkg.sv
// Contract
// - Optional down conversion, decimate 2..32, 32-bit oscillator
// - Real mode bypasses mixer; software zeroes frequency
// - Filter math 20-bit, truncated only at output
// - Crossbar lets each path take other channel
// - Optional 6 dB gain in complex path
// - Optional 3 dB gain in real path
// - Quarter-rate mix gives real output, double rate
// - Positive rotation default, register inverts mixer phase
// - Oscillator sequence multiplies real converter samples
// - Frequency word is signed two's complement
// - New frequency active only after restart/sync toggle
// - Output rate Fs/N, passband 0.8 or 0.4
// - Filters keep passband, reject aliasing stopbands
// - Sync pin sampled on clock, chosen by enable
// - Sync resets dividers, phase, loads pending frequency
package ddc_pkg;
  localparam int IN_W   = 14;
  localparam int OUT_W  = 16;
  localparam int CALC_W = 20;
  localparam int ACC_W  = 25;
  localparam int NCO_W  = 32;
  localparam int REG_AW = 8;
  localparam int CTRL_W = 12;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FREQ_A = 8'h04;
  localparam logic [7:0] OFS_FREQ_B = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0C;
  localparam logic [7:0] OFS_LIVE_A = 8'h10;
  localparam logic [7:0] OFS_LIVE_B = 8'h14;
  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int B_EN = 0, B_REAL = 1, B_G6 = 2, B_G3 = 3, B_FS4 = 4;
  localparam int B_INV = 5, B_CROSS = 6, B_SYNC_EN = 7, B_RESTART = 8;
  localparam int B_DEC_LO = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 12'h000;
  localparam logic [NCO_W-1:0]  FREQ_RST     = 32'h00000000;
  localparam logic [2:0]        DEC_CODE_MAX = 3'h4;
  localparam logic [4:0]        CNT_FULL     = 5'h1F;
  // ----------------------------------------------------------------
  // Quarter-wave cosine table and saturation limits
  // ----------------------------------------------------------------
  localparam logic [4:0][15:0] COS_TAB =
    {16'h0000, 16'h30FC, 16'h5A82, 16'h7641, 16'h7FFF};
  localparam logic signed [21:0] SAT_HI = 22'sh07FFFF;
  localparam logic signed [21:0] SAT_LO = 22'sh380000;
  typedef struct packed {
    logic               real_fmt;
    logic signed [15:0] i;
    logic signed [15:0] q;
  } out_word_s;
  typedef enum logic [1:0] {EMIT_MAIN = 2'b01, EMIT_SECOND = 2'b10} emit_e;
endpackage

// ### tb/ddc_decimator_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ddc_decimator_chk (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst_b,
  // Watched ports
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic                      samp_ready,
  input wire logic                      powerdown_or_align_pin,
  input wire logic                      powered_down,
  input wire ddc_pkg::out_word_s [1:0]  out_word,
  input wire logic [1:0]                out_valid,
  input wire logic [1:0]                out_ready
);
  import ddc_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // A stalled lane keeps its word up
  property p_v0_hold;
    out_valid[0] && !out_ready[0] |=> out_valid[0];
  endproperty
  a_v0_hold: assert property (p_v0_hold) else $error("lane 0 valid dropped");
  property p_w0_hold;
    out_valid[0] && !out_ready[0] |=> $stable(out_word[0]);
  endproperty
  a_w0_hold: assert property (p_w0_hold) else $error("lane 0 word changed");
  property p_l1_hold;
    out_valid[1] && !out_ready[1] |=> out_valid[1] && $stable(out_word[1]);
  endproperty
  a_l1_hold: assert property (p_l1_hold) else $error("lane 1 word lost");
  // Read data only in the cycle after a read
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  // Real words carry no quadrature part
  property p_real_q0;
    out_valid[0] && out_word[0].real_fmt |-> out_word[0].q == 16'h0000;
  endproperty
  a_real_q0: assert property (p_real_q0) else $error("lane 0 real word has q");
  property p_real_q1;
    out_valid[1] && out_word[1].real_fmt |-> out_word[1].q == 16'h0000;
  endproperty
  a_real_q1: assert property (p_real_q1) else $error("lane 1 real word has q");
  // Power-down follows the pin one cycle late
  property p_pd_cause;
    powered_down |-> $past(powerdown_or_align_pin);
  endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("power-down without pin");
  property p_pd_stop;
    powered_down [*2] |-> !samp_ready;
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("samples taken in power-down");
endmodule
bind ddc_decimator ddc_decimator_chk chk_u (
  .clk(clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .samp_ready(samp_ready), .powerdown_or_align_pin(powerdown_or_align_pin),
  .powered_down(powered_down), .out_word(out_word), .out_valid(out_valid),
  .out_ready(out_ready));
`default_nettype wire

// ### tb/ddc_out_sink.sv
`timescale 1ns/100ps
`default_nettype none
module ddc_out_sink (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst_b,
  // Stall request from the bench
  input wire logic                      stall,
  // Decimator output lanes
  input wire ddc_pkg::out_word_s [1:0]  out_word,
  input wire logic [1:0]                out_valid,
  output logic [1:0]                    out_ready,
  // Words taken per lane, and the last one
  output int                            n0,
  output int                            n1,
  output ddc_pkg::out_word_s [1:0]      last
);
  import ddc_pkg::*;
  // A stalled receiver holds off both lanes
  assign out_ready = stall ? 2'b00 : 2'b11;
  // I and Q are taken as one unit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      n0 <= 0;
      n1 <= 0;
      last <= '0;
    end else begin
      if (out_valid[0] && out_ready[0]) begin
        n0 <= n0 + 1;
        last[0] <= out_word[0];
      end
      if (out_valid[1] && out_ready[1]) begin
        n1 <= n1 + 1;
        last[1] <= out_word[1];
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/ddc_decimator_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ddc_decimator_tb;
  import ddc_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, samp_valid, pin, stall, refused;
  logic [REG_AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic signed [IN_W-1:0] samp_a, samp_b;
  logic samp_ready, powered_down;
  out_word_s [1:0] out_word, last;
  logic [1:0] out_valid, out_ready;
  int n0, n1, fails, comparisons, cycles, base;
  ddc_decimator dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .samp_a(samp_a), .samp_b(samp_b), .samp_valid(samp_valid), .samp_ready(samp_ready),
    .powerdown_or_align_pin(pin), .powered_down(powered_down), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready));
  ddc_out_sink sink_u (.clk(clk), .rst_b(rst_b), .stall(stall), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready), .n0(n0), .n1(n1), .last(last));
  // ----------------------------------------
  // Clock, watchdog, refusal monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rst_b && samp_valid && samp_ready === 1'b0) refused <= 1'b1;
    if (cycles == 5000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Restart bit pulsed 0-1-0 around a control value
  task automatic align(input logic [31:0] c);
    wr(OFS_CTRL, c);
    wr(OFS_CTRL, c | 32'h0000_0100);
    wr(OFS_CTRL, c);
  endtask
  // A positive ramp on A, its negative on B
  task automatic stream(input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      samp_a <= IN_W'(i * 8 + 1000);
      samp_b <= IN_W'(-(i * 8 + 1000));
      samp_valid <= 1'b1;
      @(negedge clk);
      while (samp_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    samp_valid <= 1'b0;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, samp_valid, pin, stall, refused} = '0;
    {reg_addr, reg_wdata, samp_a, samp_b} = '0;
    {fails, comparisons, cycles} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_FREQ_A, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    rd(OFS_CTRL, 32'h0000_0000);
    // Bypass with a stalled receiver: refused, then nothing lost
    stall <= 1'b1;
    fork
      stream(5);
      begin
        repeat (20) @(posedge clk);
        stall <= 1'b0;
      end
    join
    settle();
    chk(refused, 1'b1);
    chk_n(n0, 5);
    chk(last[0], {1'b1, 16'h1020, 16'h0000});
    chk(last[1], {1'b1, 16'hEFE0, 16'h0000});
    // Complex decimation at every factor, oscillator at zero
    for (int c = 0; c <= 4; c++) begin
      align((32'(c) << B_DEC_LO) | 32'h0000_0001);
      base = n0;
      stream(4 << c);
      settle();
      chk_n(n0 - base, 2);
      chk({last[0].real_fmt, last[0].i[15], last[0].q}, 18'h0);
    end
    rd(OFS_CTRL, 32'h0000_0801);
    chk_n(n1, n0);
    // Crossbar swap: lane 0 now carries the negative channel
    align(32'h0000_0041);
    stream(4);
    settle();
    chk({last[0].i[15], last[1].i[15]}, 2'b10);
    // 6 dB gain doubles the complex result, within one truncation step
    align(32'h0000_0001);
    stream(2);
    settle();
    base = last[0].i;
    align(32'h0000_0005);
    stream(2);
    settle();
    chk_n((int'(last[0].i) - 2 * base) / 2, 0);
    // Real by 4 with gain, then quarter-rate real output by 2
    for (int m = 0; m < 2; m++) begin
      align(m ? 32'h0000_0011 : 32'h0000_020B);
      base = n0;
      stream(m ? 4 : 8);
      settle();
      chk_n(n0 - base, m ? 4 : 2);
      chk({last[0].real_fmt, last[0].q}, 17'h10000);
    end
    // Pending frequency goes live only on an align event
    wr(OFS_FREQ_A, 32'h4000_0000); // +10 MHz at 40 MHz
    rd(OFS_LIVE_A, 32'h0000_0000);
    align(32'h0000_0001);
    rd(OFS_LIVE_A, 32'h4000_0000);
    wr(OFS_FREQ_B, 32'hC000_0000); // -10 MHz at 40 MHz
    wr(OFS_CTRL, 32'h0000_0081);
    // Sync toggles kept on the 64-cycle grid
    while (cycles % 64 != 0) @(posedge clk);
    pin <= 1'b1;
    repeat (2) @(posedge clk);
    pin <= 1'b0;
    rd(OFS_LIVE_B, 32'hC000_0000);
    // Quarter-rate oscillator: q positive by default, negative inverted
    align(32'h0000_0001);
    stream(2);
    settle();
    chk({last[0].q[15], |last[0].q}, 2'b01);
    align(32'h0000_0021);
    stream(2);
    settle();
    chk({last[0].q[15], |last[0].q}, 2'b11);
    // Same pin as power-down once sync is off
    wr(OFS_CTRL, 32'h0000_0001);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(powered_down, 1'b1);
    rd(OFS_STAT, 32'h0000_0001);
    pin <= 1'b0;
    settle();
    give_verdict();
  end
endmodule
`default_nettype wire
